// File: verilog/dram_timing_ctrl.v
// Purpose: Converts timing in ps to DRAM clock counts and paces commands
// Assumes: dram_ck comes from the far side and is sampled by aclk
// Notes: Registers over AXI4-Lite; commands leave on DRAM clock edges
`include "dram_timing_defs.vh"
`timescale 1ns/100ps
`default_nettype none

module dram_timing_ctrl
(
	input wire aclk,
	input wire aresetn,
	input wire [7:0] awaddr,
	input wire awvalid,
	output wire awready,
	input wire [31:0] wdata,
	input wire [3:0] wstrb,
	input wire wvalid,
	output wire wready,
	output reg [1:0] bresp,
	output reg bvalid,
	input wire bready,
	input wire [7:0] araddr,
	input wire arvalid,
	output wire arready,
	output reg [31:0] rdata,
	output reg [1:0] rresp,
	output reg rvalid,
	input wire rready,
	input wire dram_ck,
	input wire readout_burst_end,
	output reg dram_cmd_valid,
	output reg [2:0] dram_cmd_kind,
	output reg [2:0] dram_mr,
	output reg [15:0] dram_addr,
	output reg dram_sync
);

localparam [4:0] S_IDLE = 5'b00001;
localparam [4:0] S_DIV1 = 5'b00010;
localparam [4:0] S_DIV2 = 5'b00100;
localparam [4:0] S_STORE = 5'b01000;
localparam [4:0] S_NEXT = 5'b10000;

reg [4:0] ctrl;
reg [15:0] tck_ps;
reg [15:0] rate;
reg [23:0] param [0:7];
reg [15:0] res [0:3];
reg [15:0] readout_gap;
reg [4:0] state;
reg [1:0] job;
reg dirty;
reg div_start;
reg [35:0] div_num;
reg [15:0] div_den;
wire div_busy;
wire div_done;
wire [35:0] div_quot;
reg [7:0] aw_addr;
reg aw_held;
reg [31:0] w_data;
reg w_held;
reg cmd_pending;
reg [31:0] cmd_word;
reg refused;
reg ck_s1;
reg ck_s2;
reg ck_s3;
reg ck_level;
reg ck_rise;
reg [7:0] hold_cnt;
reg hold_all;
reg [7:0] sync_cnt;
reg sync_wait;
reg gap_run;
reg [15:0] gap_cnt;
wire crc_mask;
wire fast_rate;
wire slow_rate;
wire refresh_unmet;
wire [2:0] waddr_idx;
wire [2:0] kind;
wire [2:0] mr;
wire [15:0] cmd_addr;
wire is_mrs;
wire bad_preamble;
wire bad_pda;
wire blocked;
wire [7:0] mod_cyc;
wire [7:0] sync_len;
wire [7:0] cmd_len;
wire [15:0] ui_ps;
reg [23:0] p_sel;
reg [31:0] rd_word;
reg rd_ok;

assign crc_mask = ctrl[`CTRL_CRC] & ctrl[`CTRL_MASK];
assign fast_rate = (rate == `RATE_A) | (rate == `RATE_B) | (rate == `RATE_C);
assign slow_rate = rate < `RATE_SLOW;
assign refresh_unmet = {8'h0, tck_ps} > param[`P_REFI];
assign ui_ps = slow_rate ? (`TCK_1600_PS >> 1) : (tck_ps >> 1);
assign mod_cyc = param[`P_MOD][7:0];
assign sync_len = mod_cyc + `GEAR_EXTRA + {7'h0, mod_cyc[0]};
assign cmd_len = mod_cyc + {7'h0, mod_cyc[0]};
assign kind = cmd_word[`CMD_KIND_HI:0];
assign mr = cmd_word[`CMD_MR_HI:`CMD_MR_LO];
assign cmd_addr = cmd_word[31:`CMD_ADDR_LO];
assign is_mrs = kind != `KIND_OTHER;
assign bad_preamble = (mr == `MR_PREAMBLE) & ~fast_rate &
	(cmd_addr[`ADDR_TOGGLE_BIT] | cmd_addr[`ADDR_LENGTH_BIT]);
assign bad_pda = (kind == `KIND_PDA_MRS) & ~ctrl[`CTRL_VREF_OK];
assign blocked = sync_wait | ((hold_cnt != 8'h0) & (hold_all | ~is_mrs));
// Slot = (offset - 0x10) / 4
assign waddr_idx = {~aw_addr[4], aw_addr[3:2]};

cycle_divider u_div
(
	.aclk(aclk),
	.aresetn(aresetn),
	.start(div_start),
	.num(div_num),
	.den(div_den),
	.busy(div_busy),
	.done(div_done),
	.quot(div_quot)
);

// Parameter picked for the current job
always @*
begin
	case (job)
		2'd0: p_sel = crc_mask ? param[`P_WR_CM] : param[`P_WR];
		2'd1: p_sel = crc_mask ? param[`P_WTRS_CM] : param[`P_WTRS];
		2'd2: p_sel = crc_mask ? param[`P_WTRL_CM] : param[`P_WTRL];
		default: p_sel = param[`P_REFI];
	endcase
end

// Conversion sequencer
always @(posedge aclk)
begin
	if (!aresetn)
	begin
		state <= S_IDLE;
		job <= 2'd0;
		div_start <= 1'b0;
		div_num <= 36'h0;
		div_den <= 16'h1;
		res[0] <= 16'h0;
		res[1] <= 16'h0;
		res[2] <= 16'h0;
		res[3] <= 16'h0;
	end
	else
	begin
		div_start <= 1'b0;
		case (state)
			S_IDLE:
			begin
				job <= 2'd0;
				if (dirty)
					state <= S_NEXT;
			end
			S_NEXT:
			begin
				div_den <= tck_ps;
				if (job == 2'd3)
					div_num <= {12'h0, p_sel} + {20'h0, tck_ps} - 36'h1;
				else
					div_num <= {12'h0, p_sel} * `SCALE;
				div_start <= 1'b1;
				state <= S_DIV1;
			end
			S_DIV1:
			begin
				if (div_done && job == 2'd3)
					state <= S_STORE;
				else if (div_done)
				begin
					div_num <= div_quot + `CORRECTION;
					div_den <= `SCALE_DEN;
					div_start <= 1'b1;
					state <= S_DIV2;
				end
			end
			S_DIV2:
			begin
				if (div_done)
					state <= S_STORE;
			end
			S_STORE:
			begin
				res[job] <= (div_quot[35:16] != 20'h0) ? 16'hffff :
					div_quot[15:0];
				job <= job + 2'd1;
				state <= (job == 2'd3) ? S_IDLE : S_NEXT;
			end
			default: state <= S_IDLE;
		endcase
	end
end

// AXI4-Lite write side and register stores
assign awready = ~aw_held & ~bvalid;
assign wready = ~w_held & ~bvalid;

always @(posedge aclk)
begin
	if (!aresetn)
	begin
		aw_held <= 1'b0;
		w_held <= 1'b0;
		aw_addr <= 8'h0;
		w_data <= 32'h0;
		bvalid <= 1'b0;
		bresp <= `RESP_OKAY;
		ctrl <= 5'h0;
		tck_ps <= `TCK_RESET;
		rate <= `RATE_RESET;
		param[0] <= 24'h0;
		param[1] <= 24'h0;
		param[2] <= 24'h0;
		param[3] <= 24'h0;
		param[4] <= 24'h0;
		param[5] <= 24'h0;
		param[6] <= 24'h0;
		param[7] <= 24'h0;
		dirty <= 1'b1;
		cmd_pending <= 1'b0;
		cmd_word <= 32'h0;
	end
	else
	begin
		if (awvalid && awready)
		begin
			aw_addr <= awaddr;
			aw_held <= 1'b1;
		end
		if (wvalid && wready)
		begin
			w_data <= wdata;
			w_held <= 1'b1;
		end
		if (bvalid && bready)
			bvalid <= 1'b0;
		if (state == S_NEXT && job == 2'd0)
			dirty <= 1'b0;
		if (ck_rise && cmd_pending && !blocked && !dirty &&
			state == S_IDLE)
			cmd_pending <= 1'b0;
		if (aw_held && w_held)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			bvalid <= 1'b1;
			bresp <= `RESP_OKAY;
			if (aw_addr == `REG_CTRL)
			begin
				ctrl <= w_data[4:0];
				dirty <= 1'b1;
			end
			else if (aw_addr == `REG_TCK)
			begin
				tck_ps <= (w_data[15:0] == 16'h0) ? 16'h1 : w_data[15:0];
				dirty <= 1'b1;
			end
			else if (aw_addr == `REG_RATE)
				rate <= w_data[15:0];
			else if (aw_addr >= `REG_PARAM_FIRST &&
				aw_addr <= `REG_PARAM_LAST && aw_addr[1:0] == 2'b00)
			begin
				param[waddr_idx] <= w_data[23:0];
				dirty <= 1'b1;
			end
			else if (aw_addr == `REG_CMD && !cmd_pending)
			begin
				cmd_word <= w_data;
				cmd_pending <= 1'b1;
			end
			else if (aw_addr != `REG_CMD)
				bresp <= `RESP_SLVERR;
		end
	end
end

// Read decode
always @*
begin
	rd_ok = 1'b1;
	rd_word = 32'h0;
	case (araddr)
		`REG_CTRL: rd_word = {27'h0, ctrl};
		`REG_STATUS: rd_word = {26'h0, blocked, cmd_pending, refresh_unmet,
			slow_rate, refused, (state != S_IDLE) | dirty};
		`REG_TCK: rd_word = {16'h0, tck_ps};
		`REG_RATE: rd_word = {16'h0, rate};
		`REG_CMD: rd_word = cmd_word;
		`REG_READOUT_GAP: rd_word = {16'h0, readout_gap};
		`REG_UI: rd_word = {16'h0, ui_ps};
		default:
		begin
			if (araddr >= `REG_PARAM_FIRST && araddr <= `REG_PARAM_LAST &&
				araddr[1:0] == 2'b00)
				rd_word = {8'h0, param[{~araddr[4], araddr[3:2]}]};
			else if (araddr >= `REG_RES_FIRST && araddr <= `REG_RES_LAST &&
				araddr[1:0] == 2'b00)
				rd_word = {16'h0, res[araddr[3:2]]};
			else
				rd_ok = 1'b0;
		end
	endcase
end

assign arready = ~rvalid;

always @(posedge aclk)
begin
	if (!aresetn)
	begin
		rvalid <= 1'b0;
		rdata <= 32'h0;
		rresp <= `RESP_OKAY;
	end
	else if (arvalid && arready)
	begin
		rvalid <= 1'b1;
		rdata <= rd_word;
		rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
	end
	else if (rready)
		rvalid <= 1'b0;
end

// DRAM clock sampling and edge finding
always @(posedge aclk)
begin
	if (!aresetn)
	begin
		ck_s1 <= 1'b0;
		ck_s2 <= 1'b0;
		ck_s3 <= 1'b0;
		ck_level <= 1'b0;
		ck_rise <= 1'b0;
	end
	else
	begin
		ck_s1 <= dram_ck;
		ck_s2 <= ck_s1;
		ck_s3 <= ck_s2;
		ck_rise <= 1'b0;
		if (ck_s2 == ck_s3 && ck_s2 != ck_level)
		begin
			ck_level <= ck_s2;
			ck_rise <= ck_s2;
		end
	end
end

// Command pacing on DRAM clock edges
always @(posedge aclk)
begin
	if (!aresetn)
	begin
		dram_cmd_valid <= 1'b0;
		dram_cmd_kind <= 3'h0;
		dram_mr <= 3'h0;
		dram_addr <= 16'h0;
		dram_sync <= 1'b0;
		hold_cnt <= 8'h0;
		hold_all <= 1'b0;
		sync_cnt <= 8'h0;
		sync_wait <= 1'b0;
		refused <= 1'b0;
		gap_run <= 1'b0;
		gap_cnt <= 16'h0;
		readout_gap <= 16'h0;
	end
	else
	begin
		if (readout_burst_end)
		begin
			gap_run <= 1'b1;
			gap_cnt <= 16'h0;
		end
		else if (ck_rise && gap_run && gap_cnt != 16'hffff)
			gap_cnt <= gap_cnt + 16'h1;
		if (ck_rise)
		begin
			dram_cmd_valid <= 1'b0;
			dram_sync <= 1'b0;
			if (hold_cnt != 8'h0)
				hold_cnt <= hold_cnt - 8'h1;
			if (sync_wait)
			begin
				if (sync_cnt <= 8'h1)
				begin
					sync_wait <= 1'b0;
					dram_sync <= 1'b1;
					hold_cnt <= cmd_len;
					hold_all <= 1'b1;
				end
				else
					sync_cnt <= sync_cnt - 8'h1;
			end
			else if (cmd_pending && !blocked && !dirty && state == S_IDLE)
			begin
				refused <= bad_preamble | bad_pda;
				if (!(bad_preamble | bad_pda))
				begin
					dram_cmd_valid <= 1'b1;
					dram_cmd_kind <= kind;
					dram_mr <= mr;
					dram_addr <= cmd_addr;
					if (is_mrs && gap_run && !readout_burst_end)
					begin
						readout_gap <= gap_cnt;
						gap_run <= 1'b0;
					end
					if (is_mrs && mr == `MR_SEVENTH)
					begin
						hold_cnt <= `MR7_GAP;
						hold_all <= 1'b0;
					end
					if (kind == `KIND_GEAR_MRS)
					begin
						sync_wait <= 1'b1;
						sync_cnt <= sync_len;
					end
				end
			end
		end
	end
end

endmodule

`default_nettype wire

// File: verilog/dram_timing_defs.vh
// Purpose: Constants of the DRAM timing cycle converter controller
// Assumes: AXI4-Lite byte addresses, 32-bit data
// Notes: Times are in picoseconds, counts in DRAM clock cycles
`ifndef DRAM_TIMING_DEFS_VH
`define DRAM_TIMING_DEFS_VH

// Register byte offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_TCK 8'h08
`define REG_RATE 8'h0c
`define REG_PARAM_FIRST 8'h10
`define REG_PARAM_LAST 8'h2c
`define REG_CMD 8'h30
`define REG_READOUT_GAP 8'h34
`define REG_RES_FIRST 8'h40
`define REG_RES_LAST 8'h4c
`define REG_UI 8'h50

// Parameter slots, index = (offset - 0x10) / 4
`define P_WR 3'd0
`define P_WR_CM 3'd1
`define P_WTRS 3'd2
`define P_WTRS_CM 3'd3
`define P_WTRL 3'd4
`define P_WTRL_CM 3'd5
`define P_REFI 3'd6
`define P_MOD 3'd7

// Control fields
`define CTRL_CRC 0
`define CTRL_MASK 1
`define CTRL_VREF_OK 2

// Command fields and kinds
`define CMD_KIND_HI 2
`define CMD_MR_HI 6
`define CMD_MR_LO 4
`define CMD_ADDR_LO 16
`define KIND_OTHER 3'd0
`define KIND_MRS 3'd1
`define KIND_GEAR_MRS 3'd2
`define KIND_PDA_MRS 3'd3
`define MR_PREAMBLE 3'd4
`define MR_SEVENTH 3'd7
`define ADDR_TOGGLE_BIT 11
`define ADDR_LENGTH_BIT 12

// Rounding, gap and rate constants
`define SCALE 36'd1000
`define SCALE_DEN 16'd1000
`define CORRECTION 36'd974
`define MR7_GAP 8'd5
`define GEAR_EXTRA 8'd4
`define RATE_SLOW 16'd1600
`define RATE_A 16'd2400
`define RATE_B 16'd2666
`define RATE_C 16'd3200
`define TCK_1600_PS 16'd1250

// Reset values
`define TCK_RESET 16'd1250
`define RATE_RESET 16'd1600

// Bus answers
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// File: verilog/cycle_divider.v
// Purpose: Sequential restoring divider, one quotient bit per cycle
// Assumes: start only while not busy
// Notes: done pulses in the same cycle as the last bit lands in quot
`timescale 1ns/100ps
`default_nettype none

module cycle_divider
(
	input wire aclk,
	input wire aresetn,
	input wire start,
	input wire [35:0] num,
	input wire [15:0] den,
	output reg busy,
	output reg done,
	output wire [35:0] quot
);

reg [35:0] n;
reg [16:0] r;
reg [5:0] cnt;
wire [16:0] trial;

assign trial = {r[15:0], n[35]};
assign quot = n;

always @(posedge aclk)
begin
	if (!aresetn)
	begin
		n <= 36'h0;
		r <= 17'h0;
		cnt <= 6'h0;
		busy <= 1'b0;
		done <= 1'b0;
	end
	else
	begin
		done <= 1'b0;
		if (start)
		begin
			n <= num;
			r <= 17'h0;
			cnt <= 6'd36;
			busy <= 1'b1;
		end
		else if (busy)
		begin
			if (trial >= {1'b0, den})
			begin
				r <= trial - {1'b0, den};
				n <= {n[34:0], 1'b1};
			end
			else
			begin
				r <= trial;
				n <= {n[34:0], 1'b0};
			end
			cnt <= cnt - 6'h1;
			if (cnt == 6'h1)
			begin
				busy <= 1'b0;
				done <= 1'b1;
			end
		end
	end
end

endmodule

`default_nettype wire

// File: verification/dram_timing_ctrl_chk.sv
// Purpose: Port assertions for dram_timing_ctrl
// Assumes: One aclk domain, DRAM clock sampled by aclk
// Notes: Bound to every instance of the controller
`timescale 1ns/100ps
`default_nettype none
module dram_timing_ctrl_chk
(
	input wire aclk,
	input wire aresetn,
	input wire awvalid,
	input wire awready,
	input wire wvalid,
	input wire wready,
	input wire [1:0] bresp,
	input wire bvalid,
	input wire bready,
	input wire arvalid,
	input wire arready,
	input wire [31:0] rdata,
	input wire rvalid,
	input wire rready,
	input wire dram_ck,
	input wire dram_cmd_valid,
	input wire [2:0] dram_cmd_kind,
	input wire [2:0] dram_mr,
	input wire [15:0] dram_addr
);
	reg ck_q;
	reg cmd_q;
	reg after_mr7;
	reg [7:0] rises;
	wire new_cmd = dram_cmd_valid & ~cmd_q;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// DRAM clock rises since the last issued command
	always @(posedge aclk)
	begin
		ck_q <= dram_ck;
		cmd_q <= aresetn & dram_cmd_valid;
		if (!aresetn || new_cmd)
			rises <= 8'h00;
		else if (dram_ck & ~ck_q & ~&rises)
			rises <= rises + 8'h01;
		if (!aresetn)
			after_mr7 <= 1'b0;
		else if (new_cmd)
			after_mr7 <= dram_cmd_kind == 3'd1 && dram_mr == 3'd7;
	end
	property p_b_hold;
		bvalid && !bready |=> bvalid && $stable(bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("bresp moved early");
	property p_r_hold;
		rvalid && !rready |=> rvalid && $stable(rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("rdata moved early");
	property p_b_answer;
		awvalid && awready && wvalid && wready |-> ##2 bvalid;
	endproperty
	a_b_answer: assert property (p_b_answer) else $error("late bvalid");
	property p_r_answer;
		arvalid && arready |=> rvalid;
	endproperty
	a_r_answer: assert property (p_r_answer) else $error("late rvalid");
	property p_no_aw;
		bvalid |-> !awready && !wready;
	endproperty
	a_no_aw: assert property (p_no_aw) else $error("write taken early");
	property p_cmd_len;
		$rose(dram_cmd_valid) |-> dram_cmd_valid[*8] ##[10:25] !dram_cmd_valid;
	endproperty
	a_cmd_len: assert property (p_cmd_len) else $error("bad command width");
	property p_cmd_hold;
		!new_cmd |-> $stable(dram_cmd_kind) && $stable(dram_mr) && $stable(dram_addr);
	endproperty
	a_cmd_hold: assert property (p_cmd_hold) else $error("command moved");
	property p_mr7_gap;
		new_cmd && after_mr7 && dram_cmd_kind == 3'd0 |-> rises >= 8'd5;
	endproperty
	a_mr7_gap: assert property (p_mr7_gap) else $error("gap too short");
endmodule
bind dram_timing_ctrl dram_timing_ctrl_chk chk (.aclk(aclk),
	.aresetn(aresetn), .awvalid(awvalid), .awready(awready),
	.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
	.bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata),
	.rvalid(rvalid), .rready(rready), .dram_ck(dram_ck),
	.dram_cmd_valid(dram_cmd_valid), .dram_cmd_kind(dram_cmd_kind),
	.dram_mr(dram_mr), .dram_addr(dram_addr));
`default_nettype wire

// File: verification/dram_side_model.sv
// Purpose: DRAM side model: free clock and command log
// Assumes: A command counts at the rise of its valid
// Notes: Gaps are counted in DRAM clock rises
`timescale 1ns/100ps
`default_nettype none
module dram_side_model
(
	output reg dram_ck,
	input wire dram_cmd_valid,
	input wire dram_sync,
	output reg [7:0] n_cmd,
	output reg [7:0] cmd_gap,
	output reg [7:0] sync_gap
);
	reg [7:0] rises = 8'h00;
	reg [7:0] mark = 8'h00;
	initial
	begin
		dram_ck = 1'b0;
		n_cmd = 8'h00;
		cmd_gap = 8'h00;
		sync_gap = 8'h00;
		#3.3;
		forever
			#62.5 dram_ck = ~dram_ck;
	end
	always @(posedge dram_ck)
		rises <= rises + 8'h01;
	always @(posedge dram_cmd_valid)
	begin
		n_cmd <= n_cmd + 8'h01;
		cmd_gap <= rises - mark;
		mark <= rises;
	end
	always @(posedge dram_sync)
		sync_gap <= rises - mark;
endmodule
`default_nettype wire

// File: verification/dram_timing_cycle_converter_bench.sv
// Purpose: Self-checking bench for the timing converter
// Assumes: Inputs change by NBA at rising aclk
// Notes: Expected counts are worked out here
`include "dram_timing_defs.vh"
`timescale 1ns/100ps
`default_nettype none
module dram_timing_cycle_converter_bench;
	reg aclk = 1'b0;
	reg aresetn = 1'b0;
	reg [7:0] awaddr = 8'h00;
	reg [7:0] araddr = 8'h00;
	reg [31:0] wdata = 32'h0;
	reg awvalid = 1'b0;
	reg wvalid = 1'b0;
	reg bready = 1'b0;
	reg arvalid = 1'b0;
	reg rready = 1'b0;
	reg burst_end = 1'b0;
	wire [2:0] ckind, cmr;
	wire [15:0] caddr;
	wire awready, wready, bvalid, arready, rvalid, dck, cvalid, sync;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [7:0] n_cmd, cmd_gap, sync_gap;
	reg [31:0] got;
	reg [31:0] par [0:7] = '{15000, 16000, 2500, 3750, 7500, 8750, 7800000, 3};
	reg [31:0] rates [0:3] = '{1600, 2400, 2666, 3200};
	integer n_mismatch = 0;
	integer num_checks = 0;
	always #2.5 aclk = ~aclk;
	dram_timing_ctrl uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .dram_ck(dck), .readout_burst_end(burst_end),
		.dram_cmd_valid(cvalid), .dram_cmd_kind(ckind), .dram_mr(cmr),
		.dram_addr(caddr),
		.dram_sync(sync));
	dram_side_model far (.dram_ck(dck), .dram_cmd_valid(cvalid),
		.dram_sync(sync), .n_cmd(n_cmd), .cmd_gap(cmd_gap),
		.sync_gap(sync_gap));
	function [31:0] clock_cycle_count(input [31:0] ps, input [31:0] tck);
		clock_cycle_count = (ps * 1000 / tck + 974) / 1000;
	endfunction
	task summarize;
	begin
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	end
	endtask
	task check(input [31:0] g, input [31:0] e);
	begin
		num_checks = num_checks + 1;
		if (g !== e)
		begin
			n_mismatch = n_mismatch + 1;
			$display("MISMATCH %0t got %h exp %h", $time, g, e);
		end
	end
	endtask
	task hang;
	begin
		n_mismatch = n_mismatch + 1;
		$display("MISMATCH %0t wait ran out", $time);
		summarize;
	end
	endtask
	task wr(input [7:0] a, input [31:0] d, input [1:0] e);
		integer i;
	begin
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		for (i = 0; !(bvalid && bready); i = i + 1)
		begin
			if (i == 60)
				hang;
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			bready <= bvalid;
		end
		check(bresp, e);
	end
	endtask
	task rd(input [7:0] a, input [1:0] e);
		integer i;
	begin
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		for (i = 0; !(rvalid && rready); i = i + 1)
		begin
			if (i == 60)
				hang;
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
			rready <= rvalid;
		end
		got = rdata;
		check(rresp, e);
	end
	endtask
	task idle(input integer b);
		integer i;
	begin
		got[b] = 1'b1;
		for (i = 0; got[b] === 1'b1; i = i + 1)
		begin
			if (i == 150)
				hang;
			rd(`REG_STATUS, `RESP_OKAY);
		end
	end
	endtask
	task cmd(input [31:0] c);
	begin
		wr(`REG_CMD, c, `RESP_OKAY);
		idle(4);
		// Far side sees it; next one never abuts
		repeat (30) @(posedge aclk);
	end
	endtask
	task ck_wait(input v);
		integer i;
	begin
		for (i = 0; dck !== v; i = i + 1)
		begin
			if (i == 40)
				hang;
			@(posedge aclk);
		end
	end
	endtask
	task t_reset;
	begin
		rd(`REG_TCK, `RESP_OKAY);
		check(got, 32'd1250);
		rd(`REG_RATE, `RESP_OKAY);
		check(got, 32'd1600);
		rd(8'hfc, `RESP_SLVERR);
		check(got, 32'h0);
		wr(`REG_STATUS, 32'h1, `RESP_SLVERR);
	end
	endtask
	task t_convert;
		integer c;
		integer j;
	begin
		wr(`REG_TCK, 32'd937, `RESP_OKAY);
		for (j = 0; j < 8; j = j + 1)
			wr(8'h10 + 8'(j * 4), par[j], `RESP_OKAY);
		for (c = 0; c < 4; c = c + 1)
		begin
			wr(`REG_CTRL, c, `RESP_OKAY);
			idle(0);
			for (j = 0; j < 3; j = j + 1)
			begin
				rd(8'h40 + 8'(j * 4), `RESP_OKAY);
				check(got, clock_cycle_count(par[2 * j + (c == 3)], 937));
			end
		end
		rd(`REG_RES_LAST, `RESP_OKAY);
		check(got, (par[6] + 936) / 937);
		wr(8'h28, 32'd900, `RESP_OKAY);
		idle(0);
		check(got[3], 1'b1);
		wr(8'h28, par[6], `RESP_OKAY);
		idle(0);
		check(got[3], 1'b0);
	end
	endtask
	task t_rate;
		integer r;
		integer b;
		reg [7:0] n;
	begin
		wr(`REG_RATE, 32'd1333, `RESP_OKAY);
		idle(0);
		check(got[2], 1'b1);
		rd(`REG_UI, `RESP_OKAY);
		check(got, 32'd625);
		for (r = 0; r < 4; r = r + 1)
			for (b = 11; b < 13; b = b + 1)
			begin
				wr(`REG_RATE, rates[r], `RESP_OKAY);
				n = n_cmd;
				cmd(32'h41 | (32'h1 << (b + 16)));
				check(got[1], r == 0);
				check(n_cmd - n, r != 0);
			end
	end
	endtask
	task t_pda;
	begin
		wr(`REG_CTRL, 32'h0, `RESP_OKAY);
		cmd(32'h13);
		check(got[1], 1'b1);
		wr(`REG_CTRL, 32'h4, `RESP_OKAY);
		cmd(32'h13);
		check(got[1], 1'b0);
	end
	endtask
	task t_mr7;
	begin
		cmd(32'h71);
		cmd(32'h0);
		check(cmd_gap >= 8'd5, 1'b1);
	end
	endtask
	task t_gear;
		integer i;
	begin
		cmd(32'h2);
		for (i = 0; sync_gap == 8'h00; i = i + 1)
		begin
			if (i == 600)
				hang;
			@(posedge aclk);
		end
		check(sync_gap, 32'd8);
		cmd(32'h0);
		check(cmd_gap >= 8'd12, 1'b1);
	end
	endtask
	task t_readout;
	begin
		// Burst ends just after a DRAM clock fall, then three full DRAM clocks
		ck_wait(1'b1);
		ck_wait(1'b0);
		burst_end <= 1'b1;
		@(posedge aclk);
		burst_end <= 1'b0;
		ck_wait(1'b1);
		ck_wait(1'b0);
		ck_wait(1'b1);
		ck_wait(1'b0);
		ck_wait(1'b1);
		repeat (12) @(posedge aclk);
		cmd(32'h0abc0031);
		check(ckind, `KIND_MRS);
		check(cmr, 3'd3);
		check(caddr, 16'h0abc);
		rd(`REG_READOUT_GAP, `RESP_OKAY);
		check(got, 32'd3);
	end
	endtask
	initial
	begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset;
		t_convert;
		t_rate;
		t_pda;
		t_mr7;
		t_gear;
		t_readout;
		summarize;
	end
endmodule
`default_nettype wire
